/* verilog/fpd_pkg.sv */
// Purpose: constants for the fast-page memory controller
// Assumes: 20 MHz ref_clk, -60 grade timing by default
// Notes: times in ns, cycle counts derived below
// Contract
// - Random cycles at least 110/130 ns apart, never over 128K ns.
// - Row address valid at row strobe fall, held 10 ns.
// - Column address valid at column strobe fall, held 15 ns.
// - Switch address to column no sooner than 15 ns after row strobe.
// - Row to column strobe delay at least 20 ns.
// - Write line high by column strobe fall for reads.
// - Write line held high after column or row strobe rises.
// - Column address valid 30/35 ns before strobes rise in reads.
// - Early write: write line low by column fall, held 15 ns.
// - Write low pulse at least 15 ns wide.
// - Write low 15/20 ns before row and column strobes rise.
// - Page column cycles at least 40/45 ns apart.
// - Page row strobe low 60/70 ns to at most 100K ns.
// - Row strobe stays low 35/40 ns after column strobe rises.
// - Column-first refresh: column low 10 ns before row, 20 ns after.
// - Write line stable 10 ns around row fall in column-first refresh.
// - 4096 refreshes every 256 ms.
// - After power-up wait 200 us then 8 refreshes before access.
// - 12-bit row and 10-bit column on shared address lines.
// - Row-only refresh uses supplied row; column-first uses internal counter.
`default_nettype none
package fpd_pkg;
   localparam int CLK_MHZ = 20;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   localparam int ROW_W = 12;
   localparam int COL_W = 10;
   localparam int DATA_W = 32;
   localparam int ADDR_W = ROW_W + COL_W;
   localparam int T_RC_NS = 110;
   localparam int T_RP_NS = 40;
   localparam int T_RAS_NS = 60;
   localparam int T_RAH_NS = 10;
   localparam int ROW_TO_COLUMN_DELAY_NS = 20;
   localparam int T_CAS_NS = 20;
   localparam int T_CPRH_NS = 35;
   localparam int T_CSR_NS = 10;
   localparam int T_CHR_NS = 20;
   localparam int T_ACC_NS = 60;
   localparam int T_INIT_NS = 200000;
   localparam int T_REF_NS = 256000000;
   localparam int REF_COUNT = 4096;
   localparam int INIT_REFS = 8;
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int C_RP = cyc_up(T_RP_NS);
   localparam int C_RAH = cyc_up(T_RAH_NS);
   localparam int C_RCD = cyc_up(ROW_TO_COLUMN_DELAY_NS);
   localparam int C_CAS = cyc_up(T_CAS_NS);
   localparam int C_CPRH = cyc_up(T_CPRH_NS);
   localparam int C_CSR = cyc_up(T_CSR_NS);
   localparam int C_CHR = cyc_up(T_CHR_NS);
   localparam int C_RAS = cyc_up(T_RAS_NS);
   localparam int C_ACC = cyc_up(T_ACC_NS);
   localparam int C_INIT = cyc_up(T_INIT_NS);
   localparam int C_REFI = (T_REF_NS / REF_COUNT) / CLK_NS;
   localparam int CNT_W = 16;
   localparam int TMR_W = 13;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [3:0] INIT_ONE = 4'h1;
   localparam logic [ROW_W-1:0] ROW_ONE = 12'h001;
endpackage
`default_nettype wire

/* verilog/fpd_buf_if.sv */
// Purpose: carrier between controller and its read buffer
// Assumes: single clock
// Notes: valid and ready on both sides
`default_nettype none
interface fpd_buf_if;
   import fpd_pkg::*;
   logic in_valid;
   logic in_ready;
   logic [DATA_W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [DATA_W-1:0] out_data;
   modport fill(output in_valid, output in_data, input in_ready);
   modport buf_side(input in_valid, input in_data, output in_ready,
      output out_valid, output out_data, input out_ready);
   modport drain(input out_valid, input out_data, output out_ready);
endinterface
`default_nettype wire

/* verilog/fpd_buf2.sv */
// Purpose: two-entry skid buffer for read data
// Assumes: one clock
// Notes: full when both entries hold data
`default_nettype none
module fpd_buf2
   import fpd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   fpd_buf_if.buf_side b
);
   logic [DATA_W-1:0] mem_r [2];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   logic push;
   logic pop;
   assign b.in_ready = (cnt_r != 2'h2);
   assign b.out_valid = (cnt_r != 2'h0);
   assign b.out_data = mem_r[rp_r];
   assign push = b.in_valid && b.in_ready;
   assign pop = b.out_valid && b.out_ready;
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_r[wp_r] <= b.in_data;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

/* verilog/fpd_ctrl.sv */
// Purpose: host-side controller for an asynchronous fast-page memory module
// Assumes: 20 MHz clock, -60 grade timing, inputs synchronous to ref_clk
// Notes: random and page-mode accesses, both refresh kinds, power-up sequence
`default_nettype none
module fpd_ctrl
   import fpd_pkg::*;
#(
   parameter int INIT_CYCLES = C_INIT
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic refresh_row_only,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [DATA_W-1:0] rd_data,
   output logic init_done,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [ROW_W-1:0] mux_address_lines,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [DATA_W-1:0] dq_in
);
   typedef enum logic [3:0] {
      ST_PWR, ST_IDLE, ST_ROW, ST_COLADDR, ST_CAS, ST_CASHI, ST_RASHOLD,
      ST_PRE, ST_RF_CSR, ST_RF_RAS, ST_RF_HOLD
   } fpd_state_e;

   fpd_state_e st_r;
   logic [CNT_W-1:0] tmr_r;
   logic [CNT_W-1:0] ras_tmr_r;
   logic [3:0] init_cnt_r;
   logic [TMR_W-1:0] refi_r;
   logic ref_pend_r;
   logic [ROW_W-1:0] ref_row_r;
   logic [ROW_W-1:0] open_row_r;
   logic cur_write_r;
   logic [COL_W-1:0] col_r;
   logic tick;
   logic page_hit;
   logic cap_valid_r;
   logic [DATA_W-1:0] cap_data_r;
   logic buf_ready;
   logic [DATA_W-1:0] buf_data;
   logic buf_valid;

   fpd_buf_if bif();

   //------------------------------------------------------------
   // Read buffer
   //------------------------------------------------------------
   assign bif.in_valid = cap_valid_r;
   assign bif.in_data = cap_data_r;
   assign buf_ready = bif.in_ready;
   assign bif.out_ready = rd_ready || !rd_valid;
   assign buf_valid = bif.out_valid;
   assign buf_data = bif.out_data;

   fpd_buf2 u_buf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .b(bif.buf_side)
   );

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else if (rd_ready || !rd_valid) begin
         rd_valid <= buf_valid;
         rd_data <= buf_data;
      end
   end

   //------------------------------------------------------------
   // Refresh interval timer
   //------------------------------------------------------------
   assign tick = (refi_r == TMR_W'(C_REFI - 1));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         refi_r <= '0;
      end else if (tick) begin
         refi_r <= '0;
      end else begin
         refi_r <= refi_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_pend_r <= 1'b0;
      end else if (tick) begin
         ref_pend_r <= 1'b1;
      end else if (st_r == ST_RF_HOLD) begin
         // Both refresh kinds pass through the hold state exactly once
         ref_pend_r <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Control sequencer
   //------------------------------------------------------------
   assign page_hit = (req_addr[ADDR_W-1:COL_W] == open_row_r) && !ras_n;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ras_tmr_r <= '0;
      end else if (ras_n) begin
         ras_tmr_r <= '0;
      end else begin
         ras_tmr_r <= ras_tmr_r + CNT_ONE;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_PWR;
         tmr_r <= '0;
         init_cnt_r <= '0;
         init_done <= 1'b0;
         ras_n <= 1'b1;
         cas_n <= 1'b1;
         we_n <= 1'b1;
         mux_address_lines <= '0;
         dq_out <= '0;
         dq_oe <= 1'b0;
         req_ready <= 1'b0;
         open_row_r <= '0;
         ref_row_r <= '0;
         cur_write_r <= 1'b0;
         col_r <= '0;
         cap_valid_r <= 1'b0;
         cap_data_r <= '0;
      end else begin
         tmr_r <= tmr_r + CNT_ONE;
         req_ready <= 1'b0;
         if (cap_valid_r && buf_ready) begin
            cap_valid_r <= 1'b0;
         end
         unique case (st_r)
            ST_PWR: begin
               if (tmr_r >= CNT_W'(INIT_CYCLES)) begin
                  st_r <= ST_IDLE;
                  tmr_r <= '0;
               end
            end
            ST_IDLE: begin
               if (!init_done || ref_pend_r) begin
                  if (!ras_n) begin
                     ras_n <= 1'b1;
                     st_r <= ST_PRE;
                     tmr_r <= '0;
                  end else if (refresh_row_only) begin
                     mux_address_lines <= ref_row_r;
                     ras_n <= 1'b0;
                     ref_row_r <= ref_row_r + ROW_ONE;
                     st_r <= ST_RF_RAS;
                     tmr_r <= '0;
                  end else begin
                     we_n <= 1'b1;
                     cas_n <= 1'b0;
                     st_r <= ST_RF_CSR;
                     tmr_r <= '0;
                  end
               end else if (req_valid && !req_ready && !cap_valid_r) begin
                  cur_write_r <= req_write;
                  col_r <= req_addr[COL_W-1:0];
                  dq_out <= req_wdata;
                  req_ready <= 1'b1;
                  if (page_hit && ras_tmr_r < CNT_W'(C_REFI)) begin
                     mux_address_lines <= {{(ROW_W-COL_W){1'b0}}, req_addr[COL_W-1:0]};
                     we_n <= !req_write;
                     dq_oe <= req_write;
                     st_r <= ST_COLADDR;
                     tmr_r <= '0;
                  end else if (!ras_n) begin
                     ras_n <= 1'b1;
                     req_ready <= 1'b0;
                     st_r <= ST_PRE;
                     tmr_r <= '0;
                  end else begin
                     mux_address_lines <= req_addr[ADDR_W-1:COL_W];
                     open_row_r <= req_addr[ADDR_W-1:COL_W];
                     ras_n <= 1'b0;
                     st_r <= ST_ROW;
                     tmr_r <= '0;
                  end
               end
            end
            ST_ROW: begin
               if (tmr_r >= CNT_W'(C_RAH - 1)) begin
                  mux_address_lines <= {{(ROW_W-COL_W){1'b0}}, col_r};
                  we_n <= !cur_write_r;
                  dq_oe <= cur_write_r;
                  st_r <= ST_COLADDR;
                  tmr_r <= '0;
               end
            end
            ST_COLADDR: begin
               if (ras_tmr_r >= CNT_W'(C_RCD - 1)) begin
                  cas_n <= 1'b0;
                  st_r <= ST_CAS;
                  tmr_r <= '0;
               end
            end
            ST_CAS: begin
               // Hold column low long enough for every access limit
               if (tmr_r >= CNT_W'(C_CAS - 1) && ras_tmr_r >= CNT_W'(C_ACC)) begin
                  if (!cur_write_r) begin
                     cap_data_r <= dq_in;
                     cap_valid_r <= 1'b1;
                  end
                  cas_n <= 1'b1;
                  st_r <= ST_CASHI;
                  tmr_r <= '0;
               end
            end
            ST_CASHI: begin
               we_n <= 1'b1;
               dq_oe <= 1'b0;
               st_r <= ST_RASHOLD;
               tmr_r <= '0;
            end
            ST_RASHOLD: begin
               if (tmr_r >= CNT_W'(C_CPRH - 1) && ras_tmr_r >= CNT_W'(C_RAS)) begin
                  st_r <= ST_IDLE;
                  tmr_r <= '0;
               end
            end
            ST_PRE: begin
               if (tmr_r >= CNT_W'(C_RP - 1)) begin
                  st_r <= ST_IDLE;
                  tmr_r <= '0;
               end
            end
            ST_RF_CSR: begin
               if (tmr_r >= CNT_W'(C_CSR - 1)) begin
                  ras_n <= 1'b0;
                  st_r <= ST_RF_RAS;
                  tmr_r <= '0;
               end
            end
            ST_RF_RAS: begin
               if (tmr_r >= CNT_W'(C_CHR - 1)) begin
                  cas_n <= 1'b1;
               end
               if (tmr_r >= CNT_W'(C_RAS - 1)) begin
                  ras_n <= 1'b1;
                  cas_n <= 1'b1;
                  st_r <= ST_RF_HOLD;
                  tmr_r <= '0;
               end
            end
            ST_RF_HOLD: begin
               if (tmr_r >= CNT_W'(C_RP - 1)) begin
                  if (!init_done) begin
                     init_cnt_r <= init_cnt_r + INIT_ONE;
                     if (init_cnt_r == 4'(INIT_REFS - 1)) begin
                        init_done <= 1'b1;
                     end
                  end
                  st_r <= ST_IDLE;
                  tmr_r <= '0;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* sim/fpd_mem_model.sv */
// Purpose: behavioural memory module seen through the strobe pins
// Assumes: strobes and address move on controller clock edges
// Notes: idle data lines show the inverse of their last value
`default_nettype none
module fpd_mem_model
   import fpd_pkg::*;
(
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ROW_W-1:0] mux_address_lines,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_oe,
   output logic [DATA_W-1:0] dq_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [ROW_W-1:0] row_r;
   logic [ROW_W-1:0] ctr_r = '0;
   logic [ADDR_W-1:0] key;
   realtime ras_t;
   initial dq_in = '0;
   always @(negedge ras_n) begin
      #1;
      ras_t = $realtime;
      if (cas_n) row_r = mux_address_lines;
      else ctr_r = ctr_r + ROW_ONE;
   end
   always @(negedge cas_n) begin
      #1;
      key = {row_r, mux_address_lines[COL_W-1:0]};
      if (!ras_n && !we_n) mem[key] = dq_oe ? dq_out : ~dq_out;
      if (!ras_n && we_n) begin
         #14;
         if ($realtime < ras_t + 60) #(ras_t + 60 - $realtime);
         if (!ras_n && !cas_n) dq_in = mem.exists(key) ? mem[key] : ~dq_in;
      end
   end
   // Data held 3 ns after column strobe rises, then the lines invert
   always @(posedge cas_n) #3 dq_in = ~dq_in;
endmodule
`default_nettype wire

/* sim/fpd_ctrl_asserts.sv */
// Purpose: pin timing checks for fpd_ctrl
// Assumes: one clock of 50 ns, so short minimum times mean one edge
// Notes: bound to every fpd_ctrl instance
`default_nettype none
module fpd_ctrl_chk
   import fpd_pkg::*;
#(
   parameter int INIT_CYCLES = C_INIT
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_ready,
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic init_done,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ROW_W-1:0] mux_address_lines
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic ras_q_r;
   logic [15:0] cyc_r;
   logic [3:0] refs_r;
   logic [11:0] gap_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ras_q_r <= 1'b1;
         cyc_r <= 16'h0000;
         refs_r <= 4'h0;
         gap_r <= 12'h000;
      end else begin
         ras_q_r <= ras_n;
         if (cyc_r != 16'hFFFF) cyc_r <= cyc_r + 16'h0001;
         if (ras_q_r && !ras_n && refs_r != 4'hF) refs_r <= refs_r + 4'h1;
         if (ras_q_r && !ras_n) gap_r <= 12'h000;
         else if (gap_r != 12'hFFF) gap_r <= gap_r + 12'h001;
      end
   end
   a_rcd_min: assert property ($fell(cas_n) && !ras_n |-> !$past(ras_n))
      else $error("column strobe too soon after row strobe");
   a_ras_width: assert property ($fell(ras_n) |=> !ras_n)
      else $error("row strobe pulse too short");
   a_ras_precharge: assert property ($rose(ras_n) |=> ras_n)
      else $error("row precharge too short");
   a_cprh_hold: assert property ($rose(cas_n) && !$past(ras_n) |-> !ras_n)
      else $error("row strobe rose with column strobe");
   a_col_stable: assert property (!cas_n && !ras_n |-> $stable(mux_address_lines))
      else $error("address moved under column strobe");
   a_we_stable: assert property (!cas_n |-> $stable(we_n))
      else $error("write line moved under column strobe");
   a_cbr_setup: assert property ($fell(ras_n) |-> $stable(cas_n))
      else $error("column-first refresh strobe order");
   a_cbr_we: assert property ($fell(ras_n) && !cas_n |-> we_n && $past(we_n) ##1 we_n)
      else $error("write line not steady in column-first refresh");
   a_init_wait: assert property ($fell(ras_n) |-> 32'(cyc_r) + 1 >= INIT_CYCLES)
      else $error("strobe activity before power-up pause");
   a_init_refs: assert property ($rose(init_done) |-> refs_r >= 4'h8)
      else $error("too few power-up refreshes");
   a_no_early_take: assert property (!init_done |-> !req_ready)
      else $error("request taken before init");
   a_refresh_gap: assert property (init_done |-> gap_r <= 12'(C_REFI + 60))
      else $error("refresh interval overrun");
   a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read word lost under stall");
   c_cbr: cover property ($fell(ras_n) && !cas_n);
   c_write: cover property ($fell(cas_n) && !ras_n && !we_n);
   c_read: cover property ($fell(cas_n) && !ras_n && we_n);
endmodule
bind fpd_ctrl fpd_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES)) fpd_ctrl_chk_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .req_ready(req_ready), .rd_valid(rd_valid),
   .rd_ready(rd_ready), .rd_data(rd_data), .init_done(init_done), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .mux_address_lines(mux_address_lines));
`default_nettype wire

/* sim/tb_fast_page_dram_module_timing.sv */
// Purpose: self-checking bench for fpd_ctrl with a memory model
// Assumes: shortened power-up pause, 20 MHz clock
// Notes: data pattern ties each word to its address
`default_nettype none
module tb_fast_page_dram_module_timing;
   timeunit 1ns;
   timeprecision 1ps;
   import fpd_pkg::*;
   localparam int INIT_SIM = 20;
   localparam logic [ADDR_W-1:0] ADDRS [6] = '{22'h000000, 22'h0003FF, 22'h3FFC00,
      22'h3FFFFF, 22'h155AAA, 22'h2AA155};
   logic ref_clk, rst_n, req_valid, req_write, refresh_row_only, rd_ready;
   logic req_ready, rd_valid, init_done, ras_n, cas_n, we_n, dq_oe;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata, rd_data, dq_out, dq_in;
   logic [ROW_W-1:0] mux_address_lines;
   int mismatches, total_checks, ras_falls, cbr_falls;
   fpd_ctrl #(.INIT_CYCLES(INIT_SIM)) fpd_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .refresh_row_only(refresh_row_only),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .init_done(init_done),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mux_address_lines(mux_address_lines),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
   fpd_mem_model fpd_mem_model_inst (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .mux_address_lines(mux_address_lines), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(negedge ras_n) begin
      ras_falls++;
      if (cas_n === 1'b0) cbr_falls++;
   end
   function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
      return {~a[9:0], a};
   endfunction
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic ok);
      int n;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      ok = 1'b0;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge ref_clk);
         ok = (req_ready === 1'b1);
      end
      req_valid <= 1'b0;
   endtask
   task automatic pop(input logic [DATA_W-1:0] exp);
      int n;
      rd_ready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge ref_clk);
         if (rd_valid === 1'b1) break;
      end
      chk(rd_data, exp);
   endtask
   task automatic t_init(input logic row_only);
      int n;
      logic ok;
      rst_n <= 1'b0;
      refresh_row_only <= row_only;
      repeat (3) @(posedge ref_clk);
      ras_falls = 0;
      cbr_falls = 0;
      rst_n <= 1'b1;
      req_valid <= 1'b1;
      req_write <= 1'b1;
      req_addr <= ADDRS[5];
      req_wdata <= pat(ADDRS[5]);
      ok = 1'b0;
      // Request stands through power-up and must only be taken afterwards
      for (n = 0; n < 400 && !ok; n++) begin
         @(posedge ref_clk);
         ok = (req_ready === 1'b1);
         chk({31'h0, req_ready & ~init_done}, 32'h0);
      end
      req_valid <= 1'b0;
      // Power-up refreshes plus the row opened by the taken write
      chk(ras_falls, INIT_REFS + 1);
      chk(cbr_falls, row_only ? 0 : INIT_REFS);
      chk({31'h0, ok}, 32'h1);
      $display("test init done");
   endtask
   task automatic t_rw;
      logic ok;
      foreach (ADDRS[i]) begin
         issue(1'b1, ADDRS[i], pat(ADDRS[i]), ok);
         chk({31'h0, ok}, 32'h1);
      end
      foreach (ADDRS[i]) begin
         issue(1'b0, ADDRS[i], '0, ok);
         pop(pat(ADDRS[i]));
      end
      $display("test rw done");
   endtask
   task automatic t_stall;
      logic ok;
      int n, taken;
      taken = 0;
      rd_ready <= 1'b0;
      // Output register, two buffer entries and the capture stage hold four words
      for (n = 0; n < 5; n++) begin
         issue(1'b0, ADDRS[n], '0, ok);
         if (ok) taken++;
      end
      chk(taken, 4);
      for (n = 0; n < taken; n++) pop(pat(ADDRS[n]));
      $display("test stall done");
   endtask
   task automatic t_refresh(input logic row_only);
      int f, c;
      f = ras_falls;
      c = cbr_falls;
      repeat (2 * C_REFI + 500) @(posedge ref_clk);
      chk({31'h0, (ras_falls - f) inside {[2:3]}}, 32'h1);
      chk(cbr_falls - c, row_only ? 0 : ras_falls - f);
      $display("test refresh done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #(20000 * 50);
      mismatches++;
      tally_and_finish;
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = '0;
      req_wdata = '0;
      refresh_row_only = 1'b0;
      rd_ready = 1'b1;
      t_init(1'b0);
      t_rw;
      t_stall;
      t_refresh(1'b0);
      t_init(1'b1);
      t_refresh(1'b1);
      tally_and_finish;
   end
endmodule
`default_nettype wire
